// ### src/fifo_ctl_map.vh
/*
 constants of the bus-matching fifo read port and flag control.
 assumes it is included by bare name from the design files under src/.
*/
// Functional notes
// - flag-default pins plus offset load pin pick one of eight default offsets.
// - fall-through pin picks timing mode at full reset, later is serial data in.
// - half-full flag tells whether the word count is above half the depth.
// - parity place pin picks interspersed parity, only for parallel offset loads.
// - width select pins and width match pin fix port widths at full reset.
// - offset load pin picks parallel or serial, later steers access to offsets.
// - output drive enable decides whether read data is driven or floated.
// - full reset zeroes both pointers and clears the output register.
// - full reset latches the whole configuration from the pins.
// - almost-empty is low below offset n words, high at or above n.
// - almost-full is high while free space exceeds m, low at or below m.
// - flag timing pin low gives asynchronous, high synchronous programmable flags.
// - partial reset zeroes pointers and output, keeps mode, method and offsets.
// - read bits above the selected narrow width carry no meaning.
// - enabled read edge reads memory, or offsets while offset load pin is low.
// - strobed read port reads one word per strobe edge; reader ties enable low.
// - read enable gates the read clock for memory and offset reads, except a fall-through load into an empty output; strobed reads ignore it.
// - retransmit latency pin low gives zero latency, high normal latency.
// - rewind on a read edge zeroes read pointer (sets it to one at zero latency) and shows empty, keeps the rest.
// - zero latency rewind puts the first word out on the same read edge.
// - empty/valid flag shows empty when held, data valid when falling through.
// - full/space flag shows full when held, write space when falling through.
`ifndef FIFO_CTL_MAP_VH
`define FIFO_CTL_MAP_VH

// geometry
`define FC_DW          36
`define FC_AW          10
`define FC_DEPTH       11'h400
`define FC_HALF        11'h200
`define FC_ONE_PTR     11'h001
`define FC_ZERO_PTR    11'h000
`define FC_ZERO_ADDR   10'h000
`define FC_ZERO_DATA   36'h000000000
`define FC_ZERO_OFS    10'h000
`define FC_ZERO_PAD    26'h0000000

// port width codes
`define FC_WID_X36     2'h0
`define FC_WID_X18     2'h1
`define FC_WID_X9      2'h2
`define FC_MASK_X36    36'hFFFFFFFFF
`define FC_MASK_X18    36'h00003FFFF
`define FC_MASK_X9     36'h0000001FF

// interspersed parity field positions in a parallel offset word
`define FC_IP_HI_MSB   10
`define FC_IP_HI_LSB   9
`define FC_IP_LO_MSB   7
`define FC_NIP_MSB     9

// default offsets, indexed by {offset load, pick hi, pick lo}
`define FC_DEF_OFS_0   10'h07F
`define FC_DEF_OFS_1   10'h03F
`define FC_DEF_OFS_2   10'h01F
`define FC_DEF_OFS_3   10'h00F
`define FC_DEF_OFS_4   10'h007
`define FC_DEF_OFS_5   10'h0FF
`define FC_DEF_OFS_6   10'h1FF
`define FC_DEF_OFS_7   10'h003

`endif

// ### src/edge_rise.v
/*
 rising-edge detector for a read or write clock pin sampled by ref_clk.
 assumes the pin is synchronous to ref_clk and slower than half its rate.
*/
`timescale 1ns/1ps
`default_nettype none

module edge_rise (
   // clock and reset
   input  wire ref_clk,
   input  wire rst_n,
   // pin and pulse
   input  wire pin,
   output wire rise
);

   reg pin_q;

   always @(posedge ref_clk)
   begin
      if (!rst_n)
         pin_q <= 1'b0;
      else
         pin_q <= pin;
   end

   assign rise = pin & ~pin_q;

endmodule

`default_nettype wire

// ### src/threshold_flag.v
/*
 registered level-versus-threshold flag with optional update gating.
 assumes clr and update come from the same ref_clk domain.
*/
`timescale 1ns/1ps
`default_nettype none

module threshold_flag #(
   parameter       W       = 11,
   parameter [0:0] CLR_VAL = 1'b0
) (
   // clock and reset
   input  wire         ref_clk,
   input  wire         rst_n,
   // control
   input  wire         clr,
   input  wire         update,
   // compare
   input  wire [W-1:0] level,
   input  wire [W-1:0] thresh,
   output reg          flag_q
);

   always @(posedge ref_clk)
   begin
      if (!rst_n || clr)
         flag_q <= CLR_VAL;
      else if (update)
         flag_q <= (level >= thresh);
   end

endmodule

`default_nettype wire

// ### src/fifo_read_flag_ctl.v
/*
 read port, flags, resets, retransmit and configuration latch of a deep
 bus-matching fifo, all on one clock.
 assumes writer and reader pins are synchronous to ref_clk and that their
 clock or strobe pins toggle at most once every two ref_clk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_map.vh"

module fifo_read_flag_ctl (
   // clock and system reset
   input  wire                  ref_clk,
   input  wire                  rst_n,
   // reset pins
   input  wire                  full_reset_n,
   input  wire                  pointer_reset_n,
   // configuration pins, sampled during full reset
   input  wire                  flag_default_pick_lo,
   input  wire                  flag_default_pick_hi,
   input  wire                  offset_load_pin,
   input  wire                  fallthrough_serial_in_pin,
   input  wire                  parity_place_select,
   input  wire                  write_width_select,
   input  wire                  read_width_select,
   input  wire                  width_match_enable,
   input  wire                  flag_timing_select,
   input  wire                  retransmit_latency_select,
   input  wire                  endian_select_n,
   input  wire                  async_read_select_n,
   // write side
   input  wire                  write_clk_pin,
   input  wire                  write_en_n,
   input  wire                  serial_en_n,
   input  wire [`FC_DW-1:0]     write_data,
   // read side
   input  wire                  read_clk_pin,
   input  wire                  read_en_n,
   input  wire                  rewind_n,
   input  wire                  out_drive_en_n,
   // read data
   output reg  [`FC_DW-1:0]     read_data_out,
   output reg                   read_data_oe,
   // flags
   output reg                   empty_out_valid_flag,
   output reg                   full_in_space_flag,
   output reg                   half_full_flag,
   output wire                  almost_empty_flag,
   output wire                  almost_full_flag,
   // latched configuration
   output reg                   fallthrough_mode,
   output reg                   serial_prog_q,
   output reg                   interspersed_q,
   output reg                   sync_flags_q,
   output reg                   normal_rewind_q,
   output reg                   big_endian_q,
   output reg                   async_read_q,
   output reg  [1:0]            write_width_q,
   output reg  [1:0]            read_width_q
);

   ////////////////////////////////////////////////////////////////////////
   // storage and pointers
   reg  [`FC_DW-1:0] mem [0:(1<<`FC_AW)-1];
   reg  [`FC_AW:0]   wptr_q;
   reg  [`FC_AW:0]   rptr_q;
   reg  [`FC_DW-1:0] out_q;
   reg               out_valid_q;
   reg               force_empty_q;
   reg  [`FC_AW-1:0] empty_ofs_q;
   reg  [`FC_AW-1:0] full_ofs_q;
   reg               wr_ofs_sel_q;
   reg               rd_ofs_sel_q;

   wire              rd_edge;
   wire              wr_edge;
   wire [`FC_AW:0]   count;
   wire [`FC_AW:0]   free;
   wire [`FC_AW:0]   full_thresh;
   wire              mem_empty;
   wire              mem_full;
   wire              rd_go;
   wire              wr_go;
   wire              mem_we;
   wire [`FC_AW-1:0] rd_addr;
   wire [`FC_DW-1:0] rd_word;
   wire [`FC_AW-1:0] par_ofs;
   wire              any_reset;
   reg  [`FC_AW-1:0] def_ofs;
   reg  [`FC_DW-1:0] width_mask;
   reg  [1:0]        wid_w;
   reg  [1:0]        wid_r;

   assign count     = wptr_q - rptr_q;
   assign free      = `FC_DEPTH - count;
   assign mem_empty = (count == `FC_ZERO_PTR);
   assign mem_full  = (count == `FC_DEPTH);
   assign rd_addr   = rptr_q[`FC_AW-1:0];
   assign rd_word   = mem[rd_addr];
   assign any_reset = !full_reset_n || !pointer_reset_n;

   ////////////////////////////////////////////////////////////////////////
   // clock and strobe edge detection
   edge_rise u_rd_edge (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin     (read_clk_pin),
      .rise    (rd_edge)
   );

   edge_rise u_wr_edge (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .pin     (write_clk_pin),
      .rise    (wr_edge)
   );

   // strobed port reads on every edge, clocked port only when enabled
   assign rd_go = rd_edge && (async_read_q || !read_en_n);
   assign wr_go = wr_edge && !write_en_n;
   assign mem_we = wr_go && offset_load_pin && !mem_full;

   ////////////////////////////////////////////////////////////////////////
   // default offset and width decode of the configuration pins
   always @*
   begin
      case ({offset_load_pin, flag_default_pick_hi, flag_default_pick_lo})
         3'h0:    def_ofs = `FC_DEF_OFS_0;
         3'h1:    def_ofs = `FC_DEF_OFS_1;
         3'h2:    def_ofs = `FC_DEF_OFS_2;
         3'h3:    def_ofs = `FC_DEF_OFS_3;
         3'h4:    def_ofs = `FC_DEF_OFS_4;
         3'h5:    def_ofs = `FC_DEF_OFS_5;
         3'h6:    def_ofs = `FC_DEF_OFS_6;
         default: def_ofs = `FC_DEF_OFS_7;
      endcase
   end

   always @*
   begin
      wid_w = `FC_WID_X36;
      wid_r = `FC_WID_X36;
      if (width_match_enable)
      begin
         case ({write_width_select, read_width_select})
            2'h0:    wid_r = `FC_WID_X18;
            2'h1:    wid_r = `FC_WID_X9;
            2'h2:    wid_w = `FC_WID_X18;
            default: wid_w = `FC_WID_X9;
         endcase
      end
   end

   // offset word taken from the parallel data bus
   assign par_ofs = interspersed_q ?
      {write_data[`FC_IP_HI_MSB:`FC_IP_HI_LSB],
       write_data[`FC_IP_LO_MSB:0]} :
      write_data[`FC_NIP_MSB:0];

   always @*
   begin
      case (read_width_q)
         `FC_WID_X18: width_mask = `FC_MASK_X18;
         `FC_WID_X9:  width_mask = `FC_MASK_X9;
         default:     width_mask = `FC_MASK_X36;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // configuration latch
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         fallthrough_mode <= 1'b0;
         serial_prog_q    <= 1'b0;
         interspersed_q   <= 1'b0;
         sync_flags_q     <= 1'b0;
         normal_rewind_q  <= 1'b0;
         big_endian_q     <= 1'b0;
         async_read_q     <= 1'b0;
         write_width_q    <= `FC_WID_X36;
         read_width_q     <= `FC_WID_X36;
      end
      else if (!full_reset_n)
      begin
         fallthrough_mode <= fallthrough_serial_in_pin;
         serial_prog_q    <= offset_load_pin;
         interspersed_q   <= parity_place_select;
         sync_flags_q     <= flag_timing_select;
         normal_rewind_q  <= retransmit_latency_select;
         big_endian_q     <= !endian_select_n;
         async_read_q     <= !async_read_select_n;
         write_width_q    <= wid_w;
         read_width_q     <= wid_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // offset registers
   always @(posedge ref_clk)
   begin
      if (!rst_n)
      begin
         empty_ofs_q  <= `FC_ZERO_OFS;
         full_ofs_q   <= `FC_ZERO_OFS;
         wr_ofs_sel_q <= 1'b0;
      end
      else if (!full_reset_n)
      begin
         empty_ofs_q  <= def_ofs;
         full_ofs_q   <= def_ofs;
         wr_ofs_sel_q <= 1'b0;
      end
      else if (!pointer_reset_n)
         wr_ofs_sel_q <= 1'b0; // offsets kept
      else if (!offset_load_pin && serial_prog_q)
      begin
         if (wr_edge && !serial_en_n)
         begin
            empty_ofs_q <= {empty_ofs_q[`FC_AW-2:0], full_ofs_q[`FC_AW-1]};
            full_ofs_q  <= {full_ofs_q[`FC_AW-2:0], fallthrough_serial_in_pin};
         end
      end
      else if (!offset_load_pin && wr_go)
      begin
         if (wr_ofs_sel_q)
            full_ofs_q  <= par_ofs;
         else
            empty_ofs_q <= par_ofs;
         wr_ofs_sel_q <= !wr_ofs_sel_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // write pointer and memory
   always @(posedge ref_clk)
   begin
      if (!rst_n || any_reset)
         wptr_q <= `FC_ZERO_PTR;
      else if (mem_we)
         wptr_q <= wptr_q + `FC_ONE_PTR;
   end

   always @(posedge ref_clk)
   begin
      if (mem_we)
         mem[wptr_q[`FC_AW-1:0]] <= write_data;
   end

   ////////////////////////////////////////////////////////////////////////
   // read pointer, output register and retransmit
   always @(posedge ref_clk)
   begin
      if (!rst_n || any_reset)
      begin
         rptr_q        <= `FC_ZERO_PTR;
         out_q         <= `FC_ZERO_DATA;
         out_valid_q   <= 1'b0;
         force_empty_q <= 1'b0;
         rd_ofs_sel_q  <= 1'b0;
      end
      else if (rd_edge && !rewind_n)
      begin
         force_empty_q <= 1'b1;
         out_valid_q   <= 1'b0;
         if (normal_rewind_q)
            rptr_q <= `FC_ZERO_PTR;
         else
         begin
            out_q  <= mem[`FC_ZERO_ADDR];
            rptr_q <= `FC_ONE_PTR;
         end
      end
      else if (rd_go && !offset_load_pin)
      begin
         force_empty_q <= 1'b0;
         rd_ofs_sel_q  <= !rd_ofs_sel_q;
         out_q <= {`FC_ZERO_PAD, rd_ofs_sel_q ? full_ofs_q : empty_ofs_q};
      end
      else if (fallthrough_mode)
      begin
         if (rd_edge && (rd_go || !out_valid_q))
         begin
            force_empty_q <= 1'b0;
            if (!mem_empty)
            begin
               out_q       <= rd_word;
               out_valid_q <= 1'b1;
               rptr_q      <= rptr_q + `FC_ONE_PTR;
            end
            else
               out_valid_q <= 1'b0;
         end
      end
      else if (rd_go)
      begin
         force_empty_q <= 1'b0;
         if (!mem_empty)
         begin
            out_q  <= rd_word;
            rptr_q <= rptr_q + `FC_ONE_PTR;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output pins and status flags
   always @(posedge ref_clk)
   begin
      if (!rst_n || !full_reset_n)
      begin
         read_data_out        <= `FC_ZERO_DATA;
         read_data_oe         <= 1'b0;
         empty_out_valid_flag <= 1'b0;
         full_in_space_flag   <= 1'b1;
         half_full_flag       <= 1'b1;
      end
      else
      begin
         read_data_out <= out_q & width_mask;
         read_data_oe  <= !out_drive_en_n;
         if (fallthrough_mode)
         begin
            empty_out_valid_flag <= force_empty_q || !out_valid_q;
            full_in_space_flag   <= mem_full;
         end
         else
         begin
            empty_out_valid_flag <= !(force_empty_q || mem_empty);
            full_in_space_flag   <= !mem_full;
         end
         half_full_flag <= !(count > `FC_HALF);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // programmable flags
   assign full_thresh = {1'b0, full_ofs_q} + `FC_ONE_PTR;

   threshold_flag #(
      .W       (`FC_AW+1),
      .CLR_VAL (1'b0)
   ) u_almost_empty (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clr     (any_reset),
      .update  (!sync_flags_q || rd_edge),
      .level   (count),
      .thresh  ({1'b0, empty_ofs_q}),
      .flag_q  (almost_empty_flag)
   );

   threshold_flag #(
      .W       (`FC_AW+1),
      .CLR_VAL (1'b1)
   ) u_almost_full (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .clr     (any_reset),
      .update  (!sync_flags_q || wr_edge),
      .level   (free),
      .thresh  (full_thresh),
      .flag_q  (almost_full_flag)
   );

endmodule

`default_nettype wire

// ### testbench/fifo_read_flag_ctl_monitor.sv
/* assertion checker for fifo_read_flag_ctl.
   assumes it sees only the top ports, bound below. */
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_map.vh"

module fifo_read_flag_ctl_monitor (
   // clock and resets
   input wire logic              ref_clk,
   input wire logic              rst_n,
   input wire logic              full_reset_n,
   input wire logic              pointer_reset_n,
   // pins
   input wire logic              fallthrough_serial_in_pin,
   input wire logic              parity_place_select,
   input wire logic              flag_timing_select,
   input wire logic              retransmit_latency_select,
   input wire logic              read_clk_pin,
   input wire logic              read_en_n,
   input wire logic              rewind_n,
   input wire logic              out_drive_en_n,
   // outputs
   input wire logic [`FC_DW-1:0] read_data_out,
   input wire logic              read_data_oe,
   input wire logic              empty_out_valid_flag,
   input wire logic              full_in_space_flag,
   input wire logic              half_full_flag,
   input wire logic              almost_full_flag,
   input wire logic              fallthrough_mode,
   input wire logic              interspersed_q,
   input wire logic              sync_flags_q,
   input wire logic              normal_rewind_q,
   input wire logic              async_read_q,
   input wire logic [1:0]        read_width_q
);
   logic      rd_prev_q;
   wire logic rd_rise = read_clk_pin && !rd_prev_q;
   wire logic busy = !rst_n || !full_reset_n || !pointer_reset_n;

   always_ff @(posedge ref_clk)
      rd_prev_q <= read_clk_pin;

   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_n);

   ////////////////////////////////////////////////////////////////////////
   cfg_latch_a: assert property (!full_reset_n ##1 !full_reset_n |->
      fallthrough_mode == $past(fallthrough_serial_in_pin) &&
      interspersed_q == $past(parity_place_select) &&
      sync_flags_q == $past(flag_timing_select) &&
      normal_rewind_q == $past(retransmit_latency_select))
      else $error("config not latched");
   cfg_hold_a: assert property (full_reset_n ##1 full_reset_n |->
      $stable(fallthrough_mode) && $stable(interspersed_q) &&
      $stable(normal_rewind_q)) else $error("config changed");
   reset_out_a: assert property (!full_reset_n [*2] |->
      read_data_out == `FC_ZERO_DATA && !empty_out_valid_flag &&
      full_in_space_flag && half_full_flag && almost_full_flag)
      else $error("reset outputs wrong");
   oe_on_a: assert property (disable iff (busy)
      !out_drive_en_n ##1 !out_drive_en_n |-> read_data_oe)
      else $error("output not driven");
   oe_off_a: assert property (disable iff (busy)
      out_drive_en_n ##1 out_drive_en_n |-> !read_data_oe)
      else $error("output not floated");
   narrow_zero_a: assert property ((read_width_q == `FC_WID_X9) [*3] |->
      read_data_out[`FC_DW-1:9] == 27'h0) else $error("narrow bits set");
   full_implies_a: assert property (!full_in_space_flag &&
      !fallthrough_mode |-> !half_full_flag && !almost_full_flag)
      else $error("full without half or almost full");
   rewind_flag_a: assert property (disable iff (busy)
      rd_rise && !rewind_n |-> ##[1:3] empty_out_valid_flag == fallthrough_mode)
      else $error("rewind flag wrong");
   read_gate_a: assert property (disable iff (busy) rd_rise && read_en_n &&
      rewind_n && !fallthrough_mode && !async_read_q |->
      ##2 $stable(read_data_out)) else $error("ungated read");

   cover property (rd_rise && !rewind_n);
   cover property (!full_in_space_flag && !fallthrough_mode);
   cover property (fallthrough_mode && !empty_out_valid_flag);
endmodule

bind fifo_read_flag_ctl fifo_read_flag_ctl_monitor u_mon (.*);
`default_nettype wire

// ### testbench/fifo_peer_model.sv
/* far-side writer and reader logic.
   assumes its tasks are called just after a falling ref_clk edge. */
`timescale 1ns/1ps
`default_nettype none

module fifo_peer_model (
   // clock
   input wire logic         ref_clk,
   // writer
   output var logic         write_clk_pin,
   output var logic         write_en_n,
   output var logic [35:0]  write_data,
   // reader
   output var logic         read_clk_pin,
   output var logic         read_en_n,
   output var logic         rewind_n
);
   int unsigned slow;

   initial
   begin
      slow = 0;
      {write_clk_pin, write_en_n, read_clk_pin, read_en_n, rewind_n} = 5'h0B;
      write_data = 36'h0;
   end

   // one word per write clock rise, held across the sampling edge
   task automatic wr(input logic [35:0] d);
   begin
      write_data = d;
      write_en_n = 1'b0;
      write_clk_pin = 1'b1;
      @(negedge ref_clk);
      write_clk_pin = 1'b0;
      write_en_n = 1'b1;
      write_data = ~d;
      repeat (2 + slow) @(negedge ref_clk);
   end
   endtask

   // one read clock rise; enable only as asked, low for strobed reads
   task automatic rd(input logic en_n, input logic rw_n);
   begin
      read_en_n = en_n;
      rewind_n = rw_n;
      read_clk_pin = 1'b1;
      @(negedge ref_clk);
      read_clk_pin = 1'b0;
      read_en_n = 1'b1;
      rewind_n = 1'b1;
      repeat (2 + slow) @(negedge ref_clk);
   end
   endtask
endmodule
`default_nettype wire

// ### testbench/fifo_read_flag_ctl_tb.sv
/* self-checking bench for fifo_read_flag_ctl.
   assumes the checker is bound by its own file. */
`timescale 1ns/1ps
`default_nettype none
`include "fifo_ctl_map.vh"

module fifo_read_flag_ctl_tb;
   logic ref_clk, rst_n, full_reset_n, pointer_reset_n, out_drive_en_n;
   logic flag_default_pick_lo, flag_default_pick_hi, offset_load_pin;
   logic fallthrough_serial_in_pin, parity_place_select, write_width_select;
   logic read_width_select, width_match_enable, flag_timing_select;
   logic retransmit_latency_select, endian_select_n, async_read_select_n;
   logic write_clk_pin, write_en_n, serial_en_n, read_clk_pin, read_en_n;
   logic rewind_n, read_data_oe, empty_out_valid_flag, full_in_space_flag;
   logic half_full_flag, almost_empty_flag, almost_full_flag;
   logic fallthrough_mode, serial_prog_q, interspersed_q, sync_flags_q;
   logic normal_rewind_q, big_endian_q, async_read_q;
   logic [`FC_DW-1:0] write_data, read_data_out;
   logic [1:0] write_width_q, read_width_q, ww, rw;
   logic [2:0] b;
   logic [9:0] eo;
   logic [9:0] def [8];
   int bad_count = 0;
   int n_tests = 0;
   int cyc = 0;
   wire [4:0] flg = {empty_out_valid_flag, full_in_space_flag,
                     half_full_flag, almost_empty_flag, almost_full_flag};

   fifo_read_flag_ctl u_dut (.*);
   fifo_peer_model u_peer (.*);

   always #2 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      cyc <= cyc + 1;
      if (cyc == 10000)
      begin
         bad_count++;
         results;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [35:0] g, input logic [35:0] e);
   begin
      n_tests++;
      if (g !== e)
      begin
         bad_count++;
         $display("CHECK FAILED %0t: got %h want %h", $time, g, e);
      end
   end
   endtask

   // reset-sampled pins, left alone afterwards except the fall-through pin, which later carries serial offset bits
   task automatic set_cfg(input logic [9:0] c);
   begin
      {fallthrough_serial_in_pin, flag_default_pick_hi, flag_default_pick_lo,
       parity_place_select, write_width_select, read_width_select,
       width_match_enable, flag_timing_select, retransmit_latency_select,
       endian_select_n} = c;
   end
   endtask

   task automatic full_rst(input logic [9:0] c, input logic l);
   begin
      set_cfg(c);
      offset_load_pin = l;
      full_reset_n = 1'b0;
      repeat (3) @(negedge ref_clk);
      full_reset_n = 1'b1;
      offset_load_pin = 1'b1;
      @(negedge ref_clk);
   end
   endtask

   task automatic results;
   begin
      $display("checks %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      ref_clk = 1'b0;
      {rst_n, full_reset_n, pointer_reset_n, out_drive_en_n} = 4'h2;
      {serial_en_n, async_read_select_n, offset_load_pin} = 3'h6;
      def = '{`FC_DEF_OFS_0, `FC_DEF_OFS_1, `FC_DEF_OFS_2, `FC_DEF_OFS_3,
              `FC_DEF_OFS_4, `FC_DEF_OFS_5, `FC_DEF_OFS_6, `FC_DEF_OFS_7};
      set_cfg(10'h000);
      repeat (6) @(negedge ref_clk);
      rst_n = 1'b1;
      // configuration sweep over all eight default offset codes
      for (int i = 0; i < 8; i++)
      begin
         b = i[2:0];
         out_drive_en_n = b[0];
         async_read_select_n = !b[1];
         full_rst({1'b0, b[1], b[0], b[0], b[1], b[0], b[2], b[1], b[2],
                   b[0]}, b[2]);
         ww = (b[2] && b[1]) ? {b[0], !b[0]} : 2'h0;
         rw = (b[2] && !b[1]) ? {b[0], !b[0]} : 2'h0;
         chk({fallthrough_mode, serial_prog_q, interspersed_q, sync_flags_q,
              normal_rewind_q, big_endian_q, async_read_q, write_width_q,
              read_width_q}, {1'b0, b[2], b[0], b[1], b[2], !b[0], b[1], ww,
              rw});
         offset_load_pin = 1'b0;
         u_peer.rd(1'b0, 1'b1);
         chk(read_data_out, def[i]);
         u_peer.rd(1'b0, 1'b1);
         chk(read_data_out, def[i]);
         chk(read_data_oe, !b[0]);
         eo = def[i];
         if (!b[2])
         begin
            u_peer.wr(36'h4FF);
            u_peer.wr(36'h4FF);
            eo = b[0] ? 10'h2FF : 10'h0FF;
         end
         else
         begin
            // shift 0AA into both offsets, first bit lands in the empty msb
            serial_en_n = 1'b0;
            for (int s = 19; s >= 0; s--)
            begin
               fallthrough_serial_in_pin = s[0] && (s % 10 < 8);
               u_peer.wr(36'h0);
            end
            serial_en_n = 1'b1;
            eo = 10'h0AA;
         end
         pointer_reset_n = 1'b0;
         repeat (2) @(negedge ref_clk);
         pointer_reset_n = 1'b1;
         @(negedge ref_clk);
         u_peer.rd(1'b0, 1'b1);
         chk(read_data_out, eo);
         u_peer.rd(1'b0, 1'b1);
         chk(read_data_out, eo);
         offset_load_pin = 1'b1;
      end
      $display("config sweep done");
      async_read_select_n = 1'b1;
      // fill to full, read back with a zero-latency rewind
      full_rst(10'h000, 1'b0);
      chk(flg, 5'h0D);
      chk(read_data_out, 36'h0);
      for (int k = 1; k <= 1025; k++)
      begin
         u_peer.wr(36'(k));
         chk(flg, {1'b1, k < 1024, k <= 512, k >= 127, k < 897});
      end
      for (int k = 1; k <= 3; k++)
      begin
         u_peer.rd(1'b0, 1'b1);
         chk(read_data_out, 36'(k));
      end
      u_peer.rd(1'b1, 1'b1);
      chk(read_data_out, 36'h3);
      u_peer.rd(1'b0, 1'b0);
      chk({empty_out_valid_flag, read_data_out}, 37'h1);
      for (int k = 2; k <= 1024; k++)
      begin
         u_peer.rd(1'b0, 1'b1);
         chk(read_data_out, 36'(k));
         chk(flg, {k < 1024, 1'b1, k >= 512, k <= 897, k > 127});
      end
      u_peer.rd(1'b0, 1'b1);
      chk(read_data_out, 36'h400);
      $display("flow test done");
      // fall-through timing with a slow partner
      u_peer.slow = 3;
      full_rst(10'h202, 1'b0);
      chk({empty_out_valid_flag, full_in_space_flag}, 2'h2);
      u_peer.wr(36'h5A);
      u_peer.rd(1'b1, 1'b1);
      chk({empty_out_valid_flag, read_data_out}, 37'h5A);
      u_peer.rd(1'b1, 1'b0);
      chk({empty_out_valid_flag, full_in_space_flag}, 2'h2);
      u_peer.rd(1'b1, 1'b1);
      chk({empty_out_valid_flag, read_data_out}, 37'h5A);
      $display("fall-through test done");
      results;
   end
endmodule
`default_nettype wire
